// >>> hw/fabric_perf_state_selector.sv
// Purpose: picks low or high fabric performance state and reports it
// Assumes: core states arrive synchronous to clk_i
// Notes:   frequency math left to the clock generator outside
`timescale 1ns/1ps
module fabric_perf_state_selector #(
    parameter int UNITS = 4,
    parameter int THR_W = 4
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [UNITS-1:0]   core_top_state_i,
    input  wire logic [UNITS-1:0]   core_state_low_allow_flag_i,
    input  wire logic               core_state_change_i,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [5:0]              fabric_multiplier_o,
    output logic [1:0]              fabric_divisor_o,
    output logic [7:0]              fabric_voltage_code_o
);
    // =========================================================
    // register state
    logic [16:0]      entry_reg [2];          // RL1
    logic [16:0]      entry_next [2];
    logic             sw_low_state_disable_reg, sw_low_state_disable_next;
    logic             block_low_on_top_core_state_reg, block_low_on_top_core_state_next;
    logic [THR_W-1:0] low_allow_unit_threshold_reg, low_allow_unit_threshold_next;
    logic             low_perf_index_reg, low_perf_index_next;
    logic             high_perf_index_reg, high_perf_index_next;
    logic             dynamic_fabric_switch_disable_reg, dynamic_fabric_switch_disable_next;
    logic             startup_fabric_state_reg;

    // =========================================================
    // write channel
    logic [7:0]  awaddr_reg, awaddr_next;
    logic        aw_held_reg, aw_held_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        w_held_reg, w_held_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        do_write;
    logic        ctl_written;
    logic        ctl_wrote_reg;   // re-evaluate only once the new controls are registered

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] control_word();
        logic [31:0] r;
        r = 32'h0000_0000;
        r[fabric_perf_pkg::CTL_LODIS_BIT] = sw_low_state_disable_reg;
        r[fabric_perf_pkg::CTL_TOP_BIT]   = block_low_on_top_core_state_reg;
        r[fabric_perf_pkg::CTL_THR_LSB +: THR_W] = low_allow_unit_threshold_reg;
        r[fabric_perf_pkg::CTL_LOIDX_BIT] = low_perf_index_reg;
        r[fabric_perf_pkg::CTL_HIIDX_BIT] = high_perf_index_reg;
        r[fabric_perf_pkg::CTL_DYNDIS_BIT] = dynamic_fabric_switch_disable_reg;
        return r;
    endfunction

    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        awaddr_next = awaddr_reg;
        aw_held_next = aw_held_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        w_held_next = w_held_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        entry_next[0] = entry_reg[0];
        entry_next[1] = entry_reg[1];
        sw_low_state_disable_next = sw_low_state_disable_reg;
        block_low_on_top_core_state_next = block_low_on_top_core_state_reg;
        low_allow_unit_threshold_next = low_allow_unit_threshold_reg;
        low_perf_index_next = low_perf_index_reg;
        high_perf_index_next = high_perf_index_reg;
        dynamic_fabric_switch_disable_next = dynamic_fabric_switch_disable_reg;
        ctl_written = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_next = s_axi_awaddr;
            aw_held_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
            w_held_next = 1'b1;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = 2'b00;
            case ({awaddr_reg[7:2], 2'b00})
                fabric_perf_pkg::ENTRY0_OFFSET: begin
                    m = merge({15'h0000, entry_reg[0]}, wdata_reg, wstrb_reg);
                    entry_next[0] = m[16:0];
                end
                fabric_perf_pkg::ENTRY1_OFFSET: begin
                    m = merge({15'h0000, entry_reg[1]}, wdata_reg, wstrb_reg);
                    entry_next[1] = m[16:0];
                end
                fabric_perf_pkg::CONTROL_OFFSET: begin
                    m = merge(control_word(), wdata_reg, wstrb_reg);
                    sw_low_state_disable_next = m[fabric_perf_pkg::CTL_LODIS_BIT];
                    block_low_on_top_core_state_next = m[fabric_perf_pkg::CTL_TOP_BIT];
                    low_allow_unit_threshold_next = m[fabric_perf_pkg::CTL_THR_LSB +: THR_W];
                    low_perf_index_next = m[fabric_perf_pkg::CTL_LOIDX_BIT];
                    high_perf_index_next = m[fabric_perf_pkg::CTL_HIIDX_BIT];
                    dynamic_fabric_switch_disable_next = m[fabric_perf_pkg::CTL_DYNDIS_BIT];
                    ctl_written = 1'b1;                   // RL9
                end
                fabric_perf_pkg::STATUS_OFFSET, fabric_perf_pkg::CAPS_OFFSET,
                fabric_perf_pkg::CORE_OFFSET: begin
                    bresp_next = 2'b00;
                end
                default: begin
                    bresp_next = 2'b10;
                end
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // =========================================================
    // selection
    logic [THR_W:0] allow_count;
    logic           want_high;
    logic           target_idx;
    logic           any_top;

    always_comb begin
        allow_count = '0;
        for (int i = 0; i < UNITS; i++) begin
            allow_count = allow_count + {{THR_W{1'b0}}, core_state_low_allow_flag_i[i]}; // RL7
        end
        any_top = |core_top_state_i;
        want_high = dynamic_fabric_switch_disable_reg || sw_low_state_disable_reg  // RL5
                 || (block_low_on_top_core_state_reg && any_top)                   // RL6
                 || (allow_count < {1'b0, low_allow_unit_threshold_reg});          // RL7
        target_idx = want_high ? high_perf_index_reg : low_perf_index_reg;         // RL8
    end

    // =========================================================
    // transition engine
    fabric_perf_pkg::xfer_state_e state_reg, state_next;
    logic        cur_idx_reg, cur_idx_next;
    logic        pend_reg, pend_next;
    logic [15:0] timer_reg, timer_next;
    logic        eval_req;

    assign eval_req = core_state_change_i || ctl_wrote_reg;   // RL9

    always_comb begin
        state_next = state_reg;
        cur_idx_next = cur_idx_reg;
        timer_next = timer_reg;
        pend_next = pend_reg || eval_req;
        case (state_reg)
            fabric_perf_pkg::ST_STABLE: begin
                if ((pend_reg || eval_req) && target_idx != cur_idx_reg) begin
                    state_next = fabric_perf_pkg::ST_MOVING;
                    timer_next = 16'(fabric_perf_pkg::TRANSITION_CYC - 1);
                    pend_next = 1'b0;
                end else if (pend_reg || eval_req) begin
                    pend_next = 1'b0;
                end
            end
            fabric_perf_pkg::ST_MOVING: begin
                if (timer_reg == 16'h0000) begin
                    cur_idx_next = ~cur_idx_reg;             // RL17
                    state_next = fabric_perf_pkg::ST_STABLE;
                    pend_next = 1'b1;
                end else begin
                    timer_next = timer_reg - 16'h0001;
                end
            end
            default: begin
                state_next = fabric_perf_pkg::ST_STABLE;
            end
        endcase
    end

    // applied entry drives the reference clock multiplier/divisor
    logic [16:0] cur_entry;
    assign cur_entry = entry_reg[cur_idx_reg];
    always_comb begin
        fabric_multiplier_o   = cur_entry[fabric_perf_pkg::MULT_LSB +: 6];   // RL3
        fabric_divisor_o      = cur_entry[fabric_perf_pkg::DIV_LSB +: 2];
        fabric_voltage_code_o = cur_entry[fabric_perf_pkg::VOLT_LSB +: 8];
    end

    // =========================================================
    // read channel
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic        dyn_supported;

    assign dyn_supported = !dynamic_fabric_switch_disable_reg
                        && entry_reg[0][fabric_perf_pkg::EN_BIT] && entry_reg[1][fabric_perf_pkg::EN_BIT]; // RL4
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = 2'b00;
            case ({s_axi_araddr[7:2], 2'b00})
                fabric_perf_pkg::ENTRY0_OFFSET:  rdata_next = {15'h0000, entry_reg[0]};
                fabric_perf_pkg::ENTRY1_OFFSET:  rdata_next = {15'h0000, entry_reg[1]};
                fabric_perf_pkg::CONTROL_OFFSET: rdata_next = control_word();
                fabric_perf_pkg::STATUS_OFFSET:  rdata_next = {15'h0000, cur_idx_reg, cur_entry[15:0]}; // RL10
                fabric_perf_pkg::CAPS_OFFSET:    rdata_next = {29'h0000_0000, state_reg == fabric_perf_pkg::ST_MOVING,
                                                                startup_fabric_state_reg, dyn_supported};
                fabric_perf_pkg::CORE_OFFSET:    rdata_next = {24'h00_0000, 3'(allow_count), 4'h0, any_top};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = 2'b10;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            entry_reg[0] <= fabric_perf_pkg::ENTRY0_RESET;
            entry_reg[1] <= fabric_perf_pkg::ENTRY1_RESET;
            sw_low_state_disable_reg <= 1'b0;
            block_low_on_top_core_state_reg <= 1'b0;
            low_allow_unit_threshold_reg <= '0;
            low_perf_index_reg <= fabric_perf_pkg::LOIDX_RESET;
            high_perf_index_reg <= fabric_perf_pkg::HIIDX_RESET;
            dynamic_fabric_switch_disable_reg <= 1'b0;
            startup_fabric_state_reg <= fabric_perf_pkg::STARTUP_RESET;
            cur_idx_reg <= fabric_perf_pkg::STARTUP_RESET;            // RL2
            state_reg <= fabric_perf_pkg::ST_STABLE;
            pend_reg <= 1'b0;                                         // RL2
            timer_reg <= 16'h0000;
            awaddr_reg <= 8'h00;
            aw_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
            ctl_wrote_reg <= 1'b0;
        end else begin
            entry_reg[0] <= entry_next[0];
            entry_reg[1] <= entry_next[1];
            sw_low_state_disable_reg <= sw_low_state_disable_next;
            block_low_on_top_core_state_reg <= block_low_on_top_core_state_next;
            low_allow_unit_threshold_reg <= low_allow_unit_threshold_next;
            low_perf_index_reg <= low_perf_index_next;
            high_perf_index_reg <= high_perf_index_next;
            dynamic_fabric_switch_disable_reg <= dynamic_fabric_switch_disable_next;
            cur_idx_reg <= cur_idx_next;
            state_reg <= state_next;
            pend_reg <= pend_next;
            timer_reg <= timer_next;
            awaddr_reg <= awaddr_next;
            aw_held_reg <= aw_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            w_held_reg <= w_held_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ctl_wrote_reg <= ctl_written;
        end
    end

    // =========================================================
    // checks
    a_high_forced: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        sw_low_state_disable_reg |-> target_idx == high_perf_index_reg)
        else $error("disable bit did not force high index");
    a_top_block: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        (block_low_on_top_core_state_reg && any_top) |-> target_idx == high_perf_index_reg)
        else $error("top core state did not force high index");
    a_low_allowed: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
        (!want_high) |-> target_idx == low_perf_index_reg)
        else $error("low index not chosen when allowed");
    a_idx_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
        (state_reg == fabric_perf_pkg::ST_MOVING && timer_reg != 16'h0000) |=> $stable(cur_idx_reg))
        else $error("index moved mid transition");
    a_status_idx: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
        fabric_multiplier_o == entry_reg[cur_idx_reg][5:0])
        else $error("multiplier status mismatch");
    a_dyn_caps: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
        dynamic_fabric_switch_disable_reg |-> !dyn_supported)
        else $error("dynamic support reported while disabled");
    a_reeval_move: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        (eval_req && state_reg == fabric_perf_pkg::ST_STABLE && target_idx != cur_idx_reg)
        |=> state_reg == fabric_perf_pkg::ST_MOVING)
        else $error("change did not start transition");
    a_entries_two: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        $rose(state_reg == fabric_perf_pkg::ST_STABLE) |-> cur_idx_reg != $past(cur_idx_reg))
        else $error("transition ended without index change");
    a_startup: assert property (@(posedge clk_i) $fell(rst_i) |-> cur_idx_reg == startup_fabric_state_reg) // RL2
        else $error("startup state not applied");
endmodule // fabric_perf_state_selector

// >>> hw/fabric_perf_pkg.sv
// Purpose: constants for the fabric performance state selector
// Assumes: 20 MHz clk_i, AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
//
// Summary of operation
// RL1: two fabric states, each own table entry
// RL2: cold reset applies startup state entry
// RL3: frequency from reference clock times multiplier/divisor
// RL4: dynamic supported: no disable, two entries enabled
// RL5: either disable bit forces high index
// RL6: top-state block with core in zero forces high
// RL7: low-allow unit count below threshold forces high
// RL8: low index only when all conditions allow
// RL9: re-evaluate on core state or control change
// RL10: current multiplier, divisor, voltage, index readable
// RL11: firmware runs warm sequence on one core
// RL12: firmware restores saved controls at end
// RL13: firmware picks path by low-allow flag
// RL14: low-then-high path clears, waits, sets disable
// RL15: high-then-low path sets disable, waits, clears
// RL16: each wait polls index and frequency fields
// RL17: status changes only after transition completes
// RL18: firmware restores valid state after warm reset
package fabric_perf_pkg;
    // =========================================================
    // register map
    localparam logic [7:0] ENTRY0_OFFSET  = 8'h00;
    localparam logic [7:0] ENTRY1_OFFSET  = 8'h04;
    localparam logic [7:0] CONTROL_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET  = 8'h0C;
    localparam logic [7:0] CAPS_OFFSET    = 8'h10;
    localparam logic [7:0] CORE_OFFSET    = 8'h14;
    // =========================================================
    // entry fields: multiplier [5:0], divisor [7:6], voltage [15:8], enable [16]
    localparam int MULT_LSB = 0;
    localparam int DIV_LSB  = 6;
    localparam int VOLT_LSB = 8;
    localparam int EN_BIT   = 16;
    // control fields
    localparam int CTL_LODIS_BIT = 0;
    localparam int CTL_TOP_BIT   = 1;
    localparam int CTL_THR_LSB   = 4;
    localparam int CTL_LOIDX_BIT = 8;
    localparam int CTL_HIIDX_BIT = 9;
    localparam int CTL_DYNDIS_BIT = 10;
    // =========================================================
    // reset values
    localparam logic [16:0] ENTRY0_RESET = 17'h1_0A10;
    localparam logic [16:0] ENTRY1_RESET = 17'h1_1450;
    localparam logic        STARTUP_RESET = 1'b0;
    localparam logic        LOIDX_RESET   = 1'b1;
    localparam logic        HIIDX_RESET   = 1'b0;
    // =========================================================
    // transition timing
    localparam int CLK_MHZ        = 20;
    localparam int TRANSITION_NS  = 500;
    localparam int TRANSITION_CYC = (TRANSITION_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_CLK_MHZ    = 200;
    typedef enum logic [1:0] {
        ST_STABLE = 2'b01,
        ST_MOVING = 2'b10
    } xfer_state_e;
endpackage

// >>> tb/fabric_perf_state_selector_tb_top.sv
// Purpose: self-checking bench for the fabric performance state selector
// Assumes: register reset values and timing as the package defines them
// Notes:   waits on transitions allow several re-evaluations back to back
`timescale 1ns/1ps
module fabric_perf_state_selector_tb_top;
    // ==========================================================
    // signals
    logic        clk_i, rst_i, core_state_change_i;
    logic [3:0]  core_top_state_i, core_state_low_allow_flag_i, s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, fabric_voltage_code_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, fabric_divisor_o, r;
    logic [5:0]  fabric_multiplier_o;
    int          mismatches, n_compared;
    typedef struct { logic [31:0] ctl; logic [3:0] top; logic [3:0] allow; logic idx; } row_s;
    row_s rows [11] = '{
        '{32'h0000_0100, 4'h0, 4'h0, 1'b1},
        '{32'h0000_0101, 4'h0, 4'h0, 1'b0},
        '{32'h0000_0500, 4'h0, 4'h0, 1'b0},
        '{32'h0000_0102, 4'h2, 4'h0, 1'b0},
        '{32'h0000_0102, 4'h0, 4'h0, 1'b1},
        '{32'h0000_0130, 4'h0, 4'h3, 1'b0},
        '{32'h0000_0130, 4'h0, 4'h7, 1'b1},
        '{32'h0000_0140, 4'h0, 4'hF, 1'b1},
        '{32'h0000_0200, 4'h0, 4'h0, 1'b0},
        '{32'h0000_0240, 4'h0, 4'h7, 1'b1},
        '{32'h0000_0201, 4'h0, 4'hF, 1'b1}};

    fabric_perf_state_selector #(.UNITS(4), .THR_W(4)) uut (.*);

    // ==========================================================
    // clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end

    // ==========================================================
    // tasks
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        while (!s_axi_bvalid) @(posedge clk_i);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk_i);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [15:0] fields(input logic idx);
        return idx ? fabric_perf_pkg::ENTRY1_RESET[15:0] : fabric_perf_pkg::ENTRY0_RESET[15:0];
    endfunction
    task automatic settle_and_check(input logic idx);
        repeat (4 * fabric_perf_pkg::TRANSITION_CYC) @(posedge clk_i);
        axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        check(d, {15'h0, idx, fields(idx)});
        check({16'h0, fabric_voltage_code_o, fabric_divisor_o, fabric_multiplier_o}, {16'h0, fields(idx)});
    endtask
    task automatic core_change(input logic [3:0] top, input logic [3:0] allow);
        @(posedge clk_i);
        core_top_state_i            <= top;
        core_state_low_allow_flag_i <= allow;
        core_state_change_i         <= 1'b1;
        @(posedge clk_i);
        core_state_change_i <= 1'b0;
    endtask
    // bounded poll: a stuck transition shows up as a mismatch
    task automatic poll_status(input logic idx);
        axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        for (int k = 0; k < 20 && d !== {15'h0, idx, fields(idx)}; k++) begin
            axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        end
        check(d, {15'h0, idx, fields(idx)});
    endtask
    // warm-reset fabric sequence, issued from this single master only
    task automatic warm_sequence();
        logic [31:0] saved, cleared;
        logic        low_first;
        axi_read(fabric_perf_pkg::CONTROL_OFFSET, saved, r);
        cleared = saved & 32'hFFFF_FF0C;
        low_first = !core_state_low_allow_flag_i[0];
        for (int s = 0; s < 2; s++) begin
            if (low_first == (s == 0)) begin
                axi_write(fabric_perf_pkg::CONTROL_OFFSET, cleared, r);
                poll_status(saved[fabric_perf_pkg::CTL_LOIDX_BIT]);
            end else begin
                axi_write(fabric_perf_pkg::CONTROL_OFFSET, (s == 0 ? saved : cleared) | 32'h0000_0001, r);
                poll_status(saved[fabric_perf_pkg::CTL_HIIDX_BIT]);
            end
        end
        axi_write(fabric_perf_pkg::CONTROL_OFFSET, saved, r);
        axi_read(fabric_perf_pkg::CONTROL_OFFSET, d, r);
        check(d, saved);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        core_state_change_i = 1'b0;
        core_top_state_i = 4'h0;
        core_state_low_allow_flag_i = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset state: startup entry applied, table as reset
        check({16'h0, fabric_voltage_code_o, fabric_divisor_o, fabric_multiplier_o},
              {16'h0, fields(1'b0)});
        axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        check(d, {16'h0, fields(1'b0)});
        axi_read(fabric_perf_pkg::ENTRY0_OFFSET, d, r);
        check(d, {15'h0, fabric_perf_pkg::ENTRY0_RESET});
        axi_read(fabric_perf_pkg::ENTRY1_OFFSET, d, r);
        check(d, {15'h0, fabric_perf_pkg::ENTRY1_RESET});
        axi_read(fabric_perf_pkg::CONTROL_OFFSET, d, r);
        check(d, 32'h0000_0100);
        axi_read(fabric_perf_pkg::CAPS_OFFSET, d, r);
        check(d, 32'h0000_0001);
        // selection table
        foreach (rows[i]) begin
            core_change(rows[i].top, rows[i].allow);
            axi_write(fabric_perf_pkg::CONTROL_OFFSET, rows[i].ctl, r);
            settle_and_check(rows[i].idx);
        end
        // core change alone, no control write
        axi_write(fabric_perf_pkg::CONTROL_OFFSET, 32'h0000_0130, r);
        core_change(4'h0, 4'h7);
        settle_and_check(1'b1);
        core_change(4'h0, 4'h3);
        settle_and_check(1'b0);
        // status holds until the transition completes
        axi_write(fabric_perf_pkg::CONTROL_OFFSET, 32'h0000_0100, r);
        axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        check(d, {16'h0, fields(1'b0)});
        axi_read(fabric_perf_pkg::CAPS_OFFSET, d, r);
        check(d, 32'h0000_0005);
        settle_and_check(1'b1);
        // one entry disabled, then dynamic disable bit: caps reports no dynamic support
        axi_write(fabric_perf_pkg::ENTRY1_OFFSET, 32'h0000_1450, r);
        check({30'h0, r}, 32'h0);
        axi_read(fabric_perf_pkg::ENTRY1_OFFSET, d, r);
        check(d, 32'h0000_1450);
        axi_read(fabric_perf_pkg::CAPS_OFFSET, d, r);
        check({31'h0, d[0]}, 32'h0);
        axi_write(fabric_perf_pkg::ENTRY1_OFFSET, 32'h0001_1450, r);
        axi_write(fabric_perf_pkg::CONTROL_OFFSET, 32'h0000_0500, r);
        axi_read(fabric_perf_pkg::CAPS_OFFSET, d, r);
        check({31'h0, d[0]}, 32'h0);
        settle_and_check(1'b0);
        // read-only status ignores writes; unmapped is refused
        axi_write(fabric_perf_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, r);
        check({30'h0, r}, 32'h0);
        axi_read(fabric_perf_pkg::STATUS_OFFSET, d, r);
        check(d, {16'h0, fields(1'b0)});
        axi_read(8'h20, d, r);
        check({r, d[29:0]}, 32'h8000_0000);
        axi_write(8'h20, 32'h0000_0000, r);
        check({30'h0, r}, 32'h0000_0002);
        axi_read(fabric_perf_pkg::CORE_OFFSET, d, r);
        check(d, 32'h0000_0040);
        // second reset mid-run returns to startup entry
        axi_write(fabric_perf_pkg::CONTROL_OFFSET, 32'h0000_0100, r);
        settle_and_check(1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({16'h0, fabric_voltage_code_o, fabric_divisor_o, fabric_multiplier_o},
              {16'h0, fields(1'b0)});
        warm_sequence();
        core_change(4'h0, 4'h2);
        warm_sequence();
        poll_status(1'b1);
        test_done();
    end
endmodule // fabric_perf_state_selector_tb_top
